// ---- hdl/irq_mask_map.vh ----
`ifndef IRQ_MASK_MAP_VH
`define IRQ_MASK_MAP_VH

// register byte addresses
`define NORMAL_REQ_STATUS_ADDR   32'hffff0000
`define NORMAL_RAW_SIGNAL_ADDR   32'hffff0004
`define NORMAL_ENABLE_SET_ADDR   32'hffff0008
`define NORMAL_ENABLE_CLEAR_ADDR 32'hffff000c
`define PROG_INT_CONTROL_ADDR    32'hffff0010
`define VEC_CTRL_CONFIG_ADDR     32'hffff0030
`define EVT_STATUS_ADDR          32'hffff0040
`define EVT_CLEAR_ADDR           32'hffff0044
`define EVT_ENABLE_ADDR          32'hffff0048
`define FAST_REQ_STATUS_ADDR     32'hffff0100
`define FAST_RAW_SIGNAL_ADDR     32'hffff0104
`define FAST_ENABLE_SET_ADDR     32'hffff0108
`define FAST_ENABLE_CLEAR_ADDR   32'hffff010c

// reset values
`define MASK_RESET               32'h00000000
`define EVT_RESET                3'h0

// source vector bit positions
`define SRC_FAST_OR              0
`define SRC_SOFTWARE             1
`define SRC_TIMER0               3
`define SRC_ADC                  10
`define SRC_UART                 11
`define SRC_SPI                  12
`define SRC_EXT0                 13
`define SRC_EXT1                 14
`define SRC_I2C_MASTER           15
`define SRC_I2C_SLAVE            16
`define SRC_PWM_TRIP             17
`define SRC_EXT2                 18
`define SRC_EXT3                 19

// programmed interrupt control fields
`define PROG_NORMAL_BIT          1
`define PROG_FAST_BIT            2

// vectored controller config fields
`define NEST_EN_BIT              0
`define NEST_DEPTH_LSB           4
`define NEST_DEPTH_MSB           7
`define NEST_MAX_LEVELS          4'h8
`define NEST_OFF_LEVELS          4'h1

// event bits
`define EVT_NORMAL_RISE          0
`define EVT_FAST_RISE            1
`define EVT_NEST_OVERFLOW        2

`endif

// ---- hdl/pin_sync.v ----
`timescale 1ns/1ps
// two-flop synchroniser for asynchronous pin inputs
module pin_sync #(
   parameter WIDTH = 4
) (
   input  wire             sys_clk_i,
   input  wire             rst_i,
   input  wire             ce_i,
   input  wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         // first stage feeds only the second stage
         always @(posedge sys_clk_i) begin
            if (rst_i) begin
               meta_q[g] <= 1'b0;
               sync_q[g] <= 1'b0;
            end else if (ce_i) begin
               meta_q[g] <= async_i[g];
               sync_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate

   assign sync_o = sync_q;

endmodule // pin_sync

// ---- hdl/class_mask.v ----
`timescale 1ns/1ps
`include "irq_mask_map.vh"
// enable mask and masked status of one request class
module class_mask (
   input  wire        sys_clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   input  wire [31:0] wdata_i,
   input  wire        set_we_i,
   input  wire        clear_we_i,
   input  wire        other_set_we_i,
   input  wire [31:0] raw_i,
   output wire [31:0] enable_o,
   output wire [31:0] status_o
);

   reg  [31:0] enable_q;
   reg  [31:0] enable_d;

   // set port ors ones in, clear port and the other class's set port knock them out
   always @* begin
      enable_d = enable_q;
      if (set_we_i)
         enable_d = enable_q | wdata_i;
      if (clear_we_i)
         enable_d = enable_q & ~wdata_i;
      if (other_set_we_i)
         enable_d = enable_q & ~wdata_i;
   end

   // mask changes on the bus write cycle itself
   always @(posedge sys_clk_i) begin
      if (rst_i)
         enable_q <= `MASK_RESET;
      else if (ce_i)
         enable_q <= enable_d;
   end

   assign enable_o = enable_q;
   assign status_o = raw_i & enable_q;

endmodule // class_mask

// ---- hdl/dual_class_interrupt_mask_unit.v ----
`timescale 1ns/1ps
`include "irq_mask_map.vh"
// What this block does
// - same bit means same source everywhere
// - bit 0 is combined fast indication
// - software bit 1, timers bits 3 to 6
// - converter 10, uart 11, spi 12, i2c 15/16
// - pins 13,14,18,19; pwm trip bit 17
// - bits 2, 7, 8, 9 unconnected
// - normal line ORs all 32 status bits
// - raw bits follow peripheral request lines
// - enable register only sets, resets zero
// - clear register clears written ones only
// - status is raw AND enable mask
// - no priority encoding, no vector
// - fast line ORs fast status 31:1
// - fast enable clears matching normal enable
// - normal enable clears matching fast enable
// - nesting up to eight, when enabled
// - programmed register drives software bit 1
module dual_class_interrupt_mask_unit (
   input  wire        sys_clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   // register port
   input  wire [31:0] addr_i,
   input  wire [31:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output wire [31:0] rdata_o,
   // on-chip peripheral request lines, same clock
   input  wire [3:0]  timer_irq_i,
   input  wire        adc_irq_i,
   input  wire        uart_irq_i,
   input  wire        spi_irq_i,
   input  wire        i2c_master_irq_i,
   input  wire        i2c_slave_irq_i,
   input  wire        pwm_trip_irq_i,
   // external pin requests 0..3, asynchronous
   input  wire [3:0]  external_pin_irq_i,
   // core handshake for nesting depth
   input  wire        irq_enter_i,
   input  wire        irq_exit_i,
   // request lines to the core
   output wire        normal_req_o,
   output wire        fast_req_o,
   // housekeeping interrupt
   output wire        evt_irq_o
);

   // address match, used by the write decode of every register
   // the full 32-bit address is compared, so no alias of a register
   // appears anywhere else in the space; a partial decode would be
   // cheaper but would let a stray write land on a mask register
   function is_reg;
      input [31:0] a;
      input [31:0] off;
      begin
         is_reg = (a == off);
      end
   endfunction

   // ------------------------------------------------------------------
   // registers and wires
   // ------------------------------------------------------------------
   reg  [31:0] rdata_q;
   reg  [31:0] rdata_d;
   reg         sw_normal_q;
   reg         sw_fast_q;
   reg         nest_en_q;
   reg  [3:0]  nest_depth_q;
   reg  [3:0]  nest_depth_d;
   reg  [2:0]  evt_status_q;
   reg  [2:0]  evt_status_d;
   reg  [2:0]  evt_enable_q;
   reg         normal_req_prev_q;
   reg         fast_req_prev_q;
   reg         nest_overflow;

   wire [3:0]  ext_pin_sync;
   wire [31:0] periph_vec;
   wire [31:0] normal_raw;
   wire [31:0] fast_raw;
   wire [31:0] normal_en;
   wire [31:0] fast_en;
   wire [31:0] normal_status;
   wire [31:0] fast_status;
   wire        fast_or;
   wire [3:0]  nest_limit;
   wire [2:0]  evt_set;

   wire wr_normal_set   = wr_i & is_reg(addr_i, `NORMAL_ENABLE_SET_ADDR);
   wire wr_normal_clear = wr_i & is_reg(addr_i, `NORMAL_ENABLE_CLEAR_ADDR);
   wire wr_fast_set     = wr_i & is_reg(addr_i, `FAST_ENABLE_SET_ADDR);
   wire wr_fast_clear   = wr_i & is_reg(addr_i, `FAST_ENABLE_CLEAR_ADDR);
   wire wr_prog         = wr_i & is_reg(addr_i, `PROG_INT_CONTROL_ADDR);
   wire wr_config       = wr_i & is_reg(addr_i, `VEC_CTRL_CONFIG_ADDR);
   wire wr_evt_clear    = wr_i & is_reg(addr_i, `EVT_CLEAR_ADDR);
   wire wr_evt_enable   = wr_i & is_reg(addr_i, `EVT_ENABLE_ADDR);

   // ------------------------------------------------------------------
   // source vector
   // ------------------------------------------------------------------

   // pins come from outside the clock domain
   // two flops cost two cycles of latency on bits 13, 14, 18 and 19;
   // on-chip lines share our clock and go straight in, so a pin source
   // always shows up later than a timer raised in the same cycle
   // the synchroniser freezes with ce_i like every other flop here
   pin_sync #(
      .WIDTH (4)
   ) u_pin_sync (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .async_i   (external_pin_irq_i),
      .sync_o    (ext_pin_sync)
   );

   // peripheral part of the vector, common to both classes
   // bits 0 and 1 are filled per class below; 2, 7, 8, 9 and 20 up stay low
   assign periph_vec[`SRC_FAST_OR]           = 1'b0;
   assign periph_vec[`SRC_SOFTWARE]          = 1'b0;
   assign periph_vec[2]                      = 1'b0;
   assign periph_vec[`SRC_TIMER0+3:`SRC_TIMER0] = timer_irq_i;
   assign periph_vec[9:7]                    = 3'h0;
   assign periph_vec[`SRC_ADC]               = adc_irq_i;
   assign periph_vec[`SRC_UART]              = uart_irq_i;
   assign periph_vec[`SRC_SPI]               = spi_irq_i;
   assign periph_vec[`SRC_EXT0]              = ext_pin_sync[0];
   assign periph_vec[`SRC_EXT1]              = ext_pin_sync[1];
   assign periph_vec[`SRC_I2C_MASTER]        = i2c_master_irq_i;
   assign periph_vec[`SRC_I2C_SLAVE]         = i2c_slave_irq_i;
   assign periph_vec[`SRC_PWM_TRIP]          = pwm_trip_irq_i;
   assign periph_vec[`SRC_EXT2]              = ext_pin_sync[2];
   assign periph_vec[`SRC_EXT3]              = ext_pin_sync[3];
   assign periph_vec[31:20]                  = 12'h000;

   // raw vectors follow the request lines live, no latching here
   // both classes see the very same peripheral vector, so bit n names
   // one source in every register; only bit 1 differs per class
   // bit 0 carries the combined fast indication into both classes
   // bit 1 is the software source, one programmed level per class
   // hazard: a line that pulses for less than a cycle may be missed,
   // so peripherals are expected to hold their flag until cleared
   // a peripheral drops its line only when its own flag is cleared
   assign normal_raw = periph_vec
                     | {30'h0, sw_normal_q, fast_or};
   assign fast_raw   = periph_vec
                     | {30'h0, sw_fast_q, fast_or};

   // ------------------------------------------------------------------
   // per-class enable masks
   // ------------------------------------------------------------------

   // each class's set write knocks the same bits out of the other class
   // this keeps any source from being enabled in both classes at once,
   // while a source may still be off in both; the clear ports only act
   // on their own class, so software never needs a read-modify-write
   // the bus carries one write per cycle, so set and clear never meet
   class_mask u_normal_mask (
      .sys_clk_i      (sys_clk_i),
      .rst_i          (rst_i),
      .ce_i           (ce_i),
      .wdata_i        (wdata_i),
      .set_we_i       (wr_normal_set),
      .clear_we_i     (wr_normal_clear),
      .other_set_we_i (wr_fast_set),
      .raw_i          (normal_raw),
      .enable_o       (normal_en),
      .status_o       (normal_status)
   );

   class_mask u_fast_mask (
      .sys_clk_i      (sys_clk_i),
      .rst_i          (rst_i),
      .ce_i           (ce_i),
      .wdata_i        (wdata_i),
      .set_we_i       (wr_fast_set),
      .clear_we_i     (wr_fast_clear),
      .other_set_we_i (wr_normal_set),
      .raw_i          (fast_raw),
      .enable_o       (fast_en),
      .status_o       (fast_status)
   );

   // ------------------------------------------------------------------
   // core request lines
   // ------------------------------------------------------------------

   // fast OR leaves out bit 0 so it cannot feed itself back
   // both request lines are combinational from flops and inputs, so a
   // mask write shows on the line in the very next cycle
   // limitation: the lines carry no glitch filter; the core is expected
   // to sample them on this same clock
   assign fast_or      = |fast_status[31:1];
   assign fast_req_o   = fast_or;
   // plain OR, no priority encoder: software picks the source
   assign normal_req_o = |normal_status;

   // ------------------------------------------------------------------
   // programmed (software) source
   // ------------------------------------------------------------------

   // written value sets or clears each class's software bit directly
   // the bits are levels, not pulses: software must write a zero to
   // withdraw its request, the same way a peripheral drops its flag
   // reads of this register return zero, it has no read-back
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         sw_normal_q <= 1'b0;
         sw_fast_q   <= 1'b0;
      end else if (ce_i && wr_prog) begin
         sw_normal_q <= wdata_i[`PROG_NORMAL_BIT];
         sw_fast_q   <= wdata_i[`PROG_FAST_BIT];
      end
   end

   // ------------------------------------------------------------------
   // nesting depth tracking
   // ------------------------------------------------------------------

   // without nesting the core may only sit one level deep
   // depth is tracked from the core's enter and exit pulses only; the
   // request lines are never gated by it, so the core decides itself
   // whether to take a second request while a handler runs
   // an entry beyond the limit is not counted but raises an event, so
   // a runaway handler chain becomes visible to software
   // exit at depth zero is ignored rather than wrapping to fifteen
   assign nest_limit = nest_en_q ? `NEST_MAX_LEVELS : `NEST_OFF_LEVELS;

   // enter and exit in one cycle cancel; extra entries are flagged
   always @* begin
      nest_depth_d  = nest_depth_q;
      nest_overflow = 1'b0;
      if (irq_enter_i && !irq_exit_i) begin
         if (nest_depth_q < nest_limit)
            nest_depth_d = nest_depth_q + 4'h1;
         else
            nest_overflow = 1'b1;
      end else if (irq_exit_i && !irq_enter_i) begin
         if (nest_depth_q != 4'h0)
            nest_depth_d = nest_depth_q - 4'h1;
      end
   end

   // config bit only, depth is hardware state
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         nest_en_q    <= 1'b0;
         nest_depth_q <= 4'h0;
      end else if (ce_i) begin
         if (wr_config)
            nest_en_q <= wdata_i[`NEST_EN_BIT];
         nest_depth_q <= nest_depth_d;
      end
   end

   // ------------------------------------------------------------------
   // housekeeping events
   // ------------------------------------------------------------------

   // rising-edge detectors reset to the idle level of the lines, so no
   // false edge is seen when reset is released
   // events are sticky until written off; the housekeeping line is a
   // level, high while an enabled event bit stands
   assign evt_set[`EVT_NORMAL_RISE]   = normal_req_o & ~normal_req_prev_q;
   assign evt_set[`EVT_FAST_RISE]     = fast_req_o & ~fast_req_prev_q;
   assign evt_set[`EVT_NEST_OVERFLOW] = nest_overflow;

   // set beats clear so an event in the clear cycle is kept
   // losing an event there would hide a request that software has not
   // yet seen; a spurious extra event costs only one more status read
   always @* begin
      evt_status_d = evt_status_q;
      if (wr_evt_clear)
         evt_status_d = evt_status_d & ~wdata_i[2:0];
      evt_status_d = evt_status_d | evt_set;
   end

   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         evt_status_q      <= `EVT_RESET;
         evt_enable_q      <= `EVT_RESET;
         normal_req_prev_q <= 1'b0;
         fast_req_prev_q   <= 1'b0;
      end else if (ce_i) begin
         evt_status_q      <= evt_status_d;
         normal_req_prev_q <= normal_req_o;
         fast_req_prev_q   <= fast_req_o;
         if (wr_evt_enable)
            evt_enable_q <= wdata_i[2:0];
      end
   end

   assign evt_irq_o = |(evt_status_q & evt_enable_q);

   // ------------------------------------------------------------------
   // read path
   // ------------------------------------------------------------------

   // write-only and unmapped addresses answer zero
   // the read mux is combinational from live state, so a status read
   // returns what stood in the strobe cycle, not a later snapshot
   // handlers should take the status word once on entry and work from
   // that copy, so every source valid at entry is served in turn
   always @* begin
      rdata_d = 32'h00000000;
      case (addr_i)
         `NORMAL_REQ_STATUS_ADDR: rdata_d = normal_status;
         `NORMAL_RAW_SIGNAL_ADDR: rdata_d = normal_raw;
         `NORMAL_ENABLE_SET_ADDR: rdata_d = normal_en;
         `FAST_REQ_STATUS_ADDR:   rdata_d = fast_status;
         `FAST_RAW_SIGNAL_ADDR:   rdata_d = fast_raw;
         `FAST_ENABLE_SET_ADDR:   rdata_d = fast_en;
         `VEC_CTRL_CONFIG_ADDR: begin
            rdata_d[`NEST_EN_BIT] = nest_en_q;
            rdata_d[`NEST_DEPTH_MSB:`NEST_DEPTH_LSB] = nest_depth_q;
         end
         `EVT_STATUS_ADDR:        rdata_d = {29'h0, evt_status_q};
         `EVT_ENABLE_ADDR:        rdata_d = {29'h0, evt_enable_q};
         default:                 rdata_d = 32'h00000000;
      endcase
   end

   // data stands only in the cycle after the read strobe
   // returning zero outside that cycle keeps stale status off the bus,
   // at the price of the master having to take the word on time
   always @(posedge sys_clk_i) begin
      if (rst_i)
         rdata_q <= 32'h00000000;
      else if (ce_i)
         rdata_q <= rd_i ? rdata_d : 32'h00000000;
   end

   assign rdata_o = rdata_q;

endmodule // dual_class_interrupt_mask_unit

// ---- test/irq_mask_checker_properties.sv ----
`timescale 1ns/1ps
// watches the register port and request lines of the mask unit
module irq_mask_checker (
   input wire        sys_clk_i,
   input wire        rst_i,
   input wire [31:0] addr_i,
   input wire [31:0] wdata_i,
   input wire        wr_i,
   input wire        rd_i,
   input wire [31:0] rdata_o,
   input wire [3:0]  timer_irq_i,
   input wire        adc_irq_i,
   input wire        uart_irq_i,
   input wire        spi_irq_i,
   input wire        i2c_master_irq_i,
   input wire        i2c_slave_irq_i,
   input wire        pwm_trip_irq_i,
   input wire        normal_req_o,
   input wire        fast_req_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);
   // the six non-timer on-chip lines in source-bit order, so one sample covers them all
   wire [5:0] misc_w = {pwm_trip_irq_i, i2c_slave_irq_i, i2c_master_irq_i,
                        spi_irq_i, uart_irq_i, adc_irq_i};
   wire       rd_raw = rd_i && (addr_i == 32'hffff0004 || addr_i == 32'hffff0104);

   property p_reset_quiet;
      $fell(rst_i) |-> !normal_req_o && !fast_req_o;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("request after reset");
   property p_wo_zero;
      rd_i && (addr_i == 32'hffff000c || addr_i == 32'hffff010c) |=> rdata_o == 32'h0;
   endproperty
   a_wo_zero: assert property (p_wo_zero) else $error("clear register read not zero");
   property p_raw_timer;
      rd_raw |=> rdata_o[6:3] == $past(timer_irq_i) && rdata_o[9:7] == 3'h0 && !rdata_o[2];
   endproperty
   a_raw_timer: assert property (p_raw_timer) else $error("timer raw bits wrong");
   property p_raw_periph;
      rd_raw |=> {rdata_o[17:15], rdata_o[12:10]} == $past(misc_w);
   endproperty
   a_raw_periph: assert property (p_raw_periph) else $error("peripheral raw bits wrong");
   property p_raw_bit0;
      rd_raw |=> rdata_o[0] == $past(fast_req_o);
   endproperty
   a_raw_bit0: assert property (p_raw_bit0) else $error("bit 0 not fast indication");
   property p_norm_or;
      rd_i && addr_i == 32'hffff0000 |=> (rdata_o != 32'h0) == $past(normal_req_o);
   endproperty
   a_norm_or: assert property (p_norm_or) else $error("normal line not OR of status");
   property p_fast_or;
      rd_i && addr_i == 32'hffff0100 |=> (rdata_o[31:1] != 31'h0) == $past(fast_req_o);
   endproperty
   a_fast_or: assert property (p_fast_or) else $error("fast line not OR of status");
   property p_clr_all;
      wr_i && addr_i == 32'hffff000c && (&wdata_i) |=> !normal_req_o;
   endproperty
   a_clr_all: assert property (p_clr_all) else $error("normal request after full clear");
   property p_x_fast;
      wr_i && addr_i == 32'hffff0108 && (&wdata_i) |=> !normal_req_o;
   endproperty
   a_x_fast: assert property (p_x_fast) else $error("fast enable left normal enabled");
   property p_x_norm;
      wr_i && addr_i == 32'hffff0008 && (&wdata_i) |=> !fast_req_o;
   endproperty
   a_x_norm: assert property (p_x_norm) else $error("normal enable left fast enabled");
endmodule // irq_mask_checker

// ---- test/periph_model.sv ----
`timescale 1ns/1ps
// peripheral side: request lines held as levels until the bench drops them
module periph_model (
   input  wire        sys_clk_i,
   input  wire [31:0] src_i,
   output reg  [3:0]  timer_o,
   output reg  [5:0]  misc_o,
   output reg  [3:0]  pin_o
);
   initial begin
      timer_o = 4'h0;
      misc_o  = 6'h00;
      pin_o   = 4'h0;
   end
   // a flag stays up until the bench drops its bit in src_i
   always @(posedge sys_clk_i) begin
      timer_o <= src_i[6:3];
      misc_o  <= {src_i[17:15], src_i[12:10]};
   end
   // pins are asynchronous, so they move well away from the edge
   always @(posedge sys_clk_i) begin
      pin_o <= #7 {src_i[19:18], src_i[14:13]};
   end
endmodule // periph_model

// ---- test/tb_dual_class_interrupt_mask_unit.sv ----
`timescale 1ns/1ps
module tb_dual_class_interrupt_mask_unit;
   reg         sys_clk_i;
   reg         rst_i      = 1'b1;
   reg  [31:0] addr_i     = 32'h0;
   reg  [31:0] wdata_i    = 32'h0;
   reg         wr_i       = 1'b0;
   reg         rd_i       = 1'b0;
   reg  [31:0] src_q      = 32'h0;
   reg  [1:0]  core_q     = 2'h0;
   wire [31:0] rdata_o;
   wire [3:0]  timer_w;
   wire [5:0]  misc_w;
   wire [3:0]  pin_w;
   wire        normal_req_o;
   wire        fast_req_o;
   wire        evt_irq_o;
   integer     fail_count = 0;
   integer     n_tests    = 0;
   integer     cyc        = 0;
   integer     i;
   // bits 3..6 and 10..19 carry sources, the rest never rise
   localparam [31:0] CONN = 32'h000ffc78;

   periph_model periph_model_i (.sys_clk_i, .src_i(src_q), .timer_o(timer_w),
      .misc_o(misc_w), .pin_o(pin_w));
   dual_class_interrupt_mask_unit dual_class_interrupt_mask_unit_i (
      .sys_clk_i, .rst_i, .ce_i(1'b1), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .timer_irq_i(timer_w), .adc_irq_i(misc_w[0]), .uart_irq_i(misc_w[1]),
      .spi_irq_i(misc_w[2]), .i2c_master_irq_i(misc_w[3]), .i2c_slave_irq_i(misc_w[4]),
      .pwm_trip_irq_i(misc_w[5]), .external_pin_irq_i(pin_w), .irq_enter_i(core_q[1]),
      .irq_exit_i(core_q[0]), .normal_req_o, .fast_req_o, .evt_irq_o);

   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   // hang guard: the sequence needs about four hundred cycles
   always @(posedge sys_clk_i) begin
      cyc = cyc + 1;
      if (cyc == 4000) begin
         fail_count = fail_count + 1;
         tally_and_finish;
      end
   end

   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [11:0] a, input [31:0] d);
      begin
         @(posedge sys_clk_i);
         wr_i    <= 1'b1;
         addr_i  <= {20'hffff0, a};
         wdata_i <= d;
         @(posedge sys_clk_i);
         wr_i <= 1'b0;
         #1;
      end
   endtask
   // read data stands only in the cycle after the strobe
   task rd(input [11:0] a, input [31:0] e);
      begin
         @(posedge sys_clk_i);
         rd_i   <= 1'b1;
         addr_i <= {20'hffff0, a};
         @(posedge sys_clk_i);
         rd_i <= 1'b0;
         #1 chk(rdata_o, e);
      end
   endtask
   // four edges cover the model register and the two pin sync flops
   task put_src(input [31:0] v);
      begin
         @(posedge sys_clk_i);
         src_q <= v;
         repeat (4) @(posedge sys_clk_i);
      end
   endtask
   task pulse(input [1:0] v);
      begin
         @(posedge sys_clk_i);
         core_q <= v;
         @(posedge sys_clk_i);
         core_q <= 2'h0;
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", n_tests, fail_count);
         if (fail_count == 0 && n_tests > 0) begin
            $display("Result: passed");
         end else begin
            $display("Result: failed");
         end
         $finish;
      end
   endtask

   initial begin
      repeat (3) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      // reset state, write-only and unmapped places
      rd(12'h008, 32'h0);
      rd(12'h108, 32'h0);
      rd(12'h000, 32'h0);
      rd(12'h00c, 32'h0);
      rd(12'h10c, 32'h0);
      rd(12'h200, 32'h0);
      // walk a single source across every bit of both raw vectors
      for (i = 0; i < 32; i = i + 1) begin
         put_src(32'h1 << i);
         rd(12'h004, (32'h1 << i) & CONN);
         rd(12'h104, (32'h1 << i) & CONN);
      end
      // set-only enable, clear register, masked status
      put_src(32'h408);
      wr(12'h008, 32'h8);
      wr(12'h008, 32'h0);
      rd(12'h008, 32'h8);
      rd(12'h000, 32'h8);
      chk(normal_req_o, 32'h1);
      wr(12'h00c, 32'h400);
      rd(12'h008, 32'h8);
      // housekeeping interrupt: raised, masked, cleared
      wr(12'h048, 32'h1);
      rd(12'h040, 32'h1);
      chk(evt_irq_o, 32'h1);
      wr(12'h048, 32'h0);
      chk(evt_irq_o, 32'h0);
      wr(12'h044, 32'h1);
      rd(12'h040, 32'h0);
      // fast class takes the sources and feeds bit 0 of both classes
      wr(12'h108, 32'h408);
      rd(12'h008, 32'h0);
      rd(12'h100, 32'h408);
      chk(fast_req_o, 32'h1);
      rd(12'h004, 32'h409);
      rd(12'h104, 32'h409);
      wr(12'h008, 32'h1);
      chk(normal_req_o, 32'h1);
      wr(12'h008, 32'h400);
      rd(12'h108, 32'h8);
      wr(12'h10c, 32'h8);
      chk(fast_req_o, 32'h0);
      rd(12'h000, 32'h400);
      // programmed source moves from the normal class to the fast class
      wr(12'h00c, 32'hffffffff);
      wr(12'h010, 32'h2);
      rd(12'h004, 32'h40a);
      wr(12'h008, 32'h2);
      chk(normal_req_o, 32'h1);
      wr(12'h010, 32'h4);
      rd(12'h104, 32'h40a);
      chk(normal_req_o, 32'h0);
      rd(12'h010, 32'h0);
      wr(12'h010, 32'h0);
      // one level without nesting, eight with it
      wr(12'h044, 32'h7);
      pulse(2'b10);
      pulse(2'b10);
      rd(12'h030, 32'h10);
      rd(12'h040, 32'h4);
      pulse(2'b01);
      wr(12'h030, 32'h1);
      for (i = 0; i < 8; i = i + 1) pulse(2'b10);
      pulse(2'b11);
      rd(12'h030, 32'h81);
      wr(12'h044, 32'h7);
      pulse(2'b10);
      rd(12'h040, 32'h4);
      // a full-width enable in one class empties the other
      wr(12'h108, 32'hffffffff);
      rd(12'h008, 32'h0);
      wr(12'h008, 32'hffffffff);
      rd(12'h108, 32'h0);
      chk(fast_req_o, 32'h0);
      tally_and_finish;
   end
endmodule // tb_dual_class_interrupt_mask_unit

bind dual_class_interrupt_mask_unit irq_mask_checker irq_mask_checker_i (
   .sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .timer_irq_i,
   .adc_irq_i, .uart_irq_i, .spi_irq_i, .i2c_master_irq_i, .i2c_slave_irq_i,
   .pwm_trip_irq_i, .normal_req_o, .fast_req_o);
